/* File: verilog/rtks_consts.svh */
// Notes on behaviour
// RULE_01 - both enables low: everything off, standby
// RULE_02 - enable high starts oscillator, pll, clock
// RULE_03 - enable only: clock out, no rf
// RULE_04 - carrier locks at thirty-two times crystal
// RULE_05 - clock output is crystal divided by four
// RULE_06 - lock and stable clock within 3 ms
// RULE_07 - controller waits 3 ms before keying
// RULE_08 - both high: amplifier on with rest
// RULE_09 - ask: amplifier follows key enable input
// RULE_10 - fsk: key held high, switch pulls crystal
// RULE_11 - switch closed lowers transmitted frequency
// RULE_12 - shutdown: key low first, then enable
// RULE_13 - symbol rate: 50 kBaud ask, 32 kBaud fsk
// RULE_14 - controller times wait, never keys unenabled
`ifndef RTKS_CONSTS_SVH
`define RTKS_CONSTS_SVH
`define RTKS_CLK_MHZ 50
`define RTKS_LOCK_MS 3
`define RTKS_LOCK_CYC (`RTKS_LOCK_MS * 1000 * `RTKS_CLK_MHZ)
`define RTKS_PLL_MULT 32
`define RTKS_CLK_DIV 4
`define RTKS_ASK_BAUD 50000
`define RTKS_FSK_BAUD 32000
`define RTKS_ASK_BIT_CYC (`RTKS_CLK_MHZ * 1000000 / `RTKS_ASK_BAUD)
`define RTKS_FSK_BIT_CYC ((`RTKS_CLK_MHZ * 1000000 + `RTKS_FSK_BAUD - 1) / `RTKS_FSK_BAUD)
`define RTKS_FIFO_DEPTH 4
`define RTKS_FIFO_WIDTH 1
`endif

/* File: verilog/rtks_pkg.sv */
package rtks_pkg;
	typedef enum logic [2:0] {
		RTKS_DEV_STANDBY,
		RTKS_DEV_LOCKING,
		RTKS_DEV_CLOCKING,
		RTKS_DEV_TRANSMIT
	} rtks_dev_state_t;
	typedef enum logic [2:0] {
		RTKS_HOST_IDLE,
		RTKS_HOST_WAKE,
		RTKS_HOST_SEND,
		RTKS_HOST_TAIL,
		RTKS_HOST_SLEEP
	} rtks_host_state_t;
endpackage : rtks_pkg

/* File: verilog/rtks_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface rtks_link_if;
	logic chip_en;
	logic amp_key_en;
	logic fsk_sw_out;
	logic fsk_sw_oe;
	logic dev_clk;
	modport device (input chip_en, input amp_key_en, input fsk_sw_out, input fsk_sw_oe, output dev_clk);
	modport host (output chip_en, output amp_key_en, output fsk_sw_out, output fsk_sw_oe, input dev_clk);
endinterface : rtks_link_if
`default_nettype wire

/* File: verilog/rtks_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module rtks_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic [AW:0] cnt;
	} rtks_fifo_st_t;
	rtks_fifo_st_t st, next_st;
	logic push, pop;
	always_comb begin
		next_st = st;
		push = in_valid && (st.cnt != (AW+1)'(DEPTH));
		pop = out_ready && (st.cnt != '0);
		if (push) begin
			next_st.mem[st.wr] = in_data;
			next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
		end
		if (push && !pop) begin
			next_st.cnt = st.cnt + 1'b1;
		end else if (pop && !push) begin
			next_st.cnt = st.cnt - 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign in_ready = (st.cnt != (AW+1)'(DEPTH));
	assign out_valid = (st.cnt != '0);
	assign out_data = st.mem[st.rd];
endmodule : rtks_fifo
`default_nettype wire

/* File: verilog/rtks_device.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rtks_consts.svh"
module rtks_device import rtks_pkg::*; #(
	parameter int LOCK_CYC = `RTKS_LOCK_CYC
) (
	input wire logic clk,
	input wire logic srst,
	rtks_link_if.device link,
	output logic osc_on,
	output logic pll_locked,
	output logic clk_drv_on,
	output logic amp_on,
	output logic freq_low,
	output logic [5:0] pll_mult,
	output logic [3:0] mode
);
	// ===================================================
	// input synchronisers: link pins come from another party
	typedef struct packed {
		logic [2:0] en_sy;
		logic [2:0] key_sy;
		logic [2:0] sw_sy;
		logic en;
		logic key;
		logic sw_low;
		rtks_dev_state_t state;
		logic [31:0] lock_cnt;
		logic [1:0] div;
		logic dclk;
		logic osc_on;
		logic pll_locked;
		logic clk_drv_on;
		logic amp_on;
		logic freq_low;
		logic [5:0] pll_mult;
		logic [3:0] mode;
	} rtks_dev_st_t;
	rtks_dev_st_t st, next_st;
	// ===================================================
	// power mode sequencing
	always_comb begin
		next_st = st;
		next_st.en_sy = {st.en_sy[1:0], link.chip_en};
		next_st.key_sy = {st.key_sy[1:0], link.amp_key_en};
		// switch closed means pin driven low to ground
		next_st.sw_sy = {st.sw_sy[1:0], link.fsk_sw_oe && !link.fsk_sw_out};
		if (st.en_sy[2] == st.en_sy[1]) begin
			next_st.en = st.en_sy[2];
		end
		if (st.key_sy[2] == st.key_sy[1]) begin
			next_st.key = st.key_sy[2];
		end
		if (st.sw_sy[2] == st.sw_sy[1]) begin
			next_st.sw_low = st.sw_sy[2];
		end
		case (st.state)
			RTKS_DEV_STANDBY: begin
				next_st.lock_cnt = '0;
				if (st.en) begin
					next_st.state = RTKS_DEV_LOCKING; // [RULE_02]
				end
			end
			RTKS_DEV_LOCKING: begin
				next_st.lock_cnt = st.lock_cnt + 32'h0000_0001;
				// seven cycles are taken off, five of pin sync and entry and two more, so lock lands before the host's wait ends
				if (!st.en) begin
					next_st.state = RTKS_DEV_STANDBY;
				end else if (st.lock_cnt >= 32'(LOCK_CYC - 7)) begin
					next_st.state = RTKS_DEV_CLOCKING; // [RULE_06]
				end
			end
			RTKS_DEV_CLOCKING: begin
				if (!st.en) begin
					next_st.state = RTKS_DEV_STANDBY;
				end else if (st.key) begin
					next_st.state = RTKS_DEV_TRANSMIT; // [RULE_08]
				end
			end
			RTKS_DEV_TRANSMIT: begin
				if (!st.en) begin
					next_st.state = RTKS_DEV_STANDBY;
				end else if (!st.key) begin
					next_st.state = RTKS_DEV_CLOCKING; // [RULE_09]
				end
			end
			default: next_st.state = RTKS_DEV_STANDBY;
		endcase
		// off in standby, running from enable onward
		next_st.osc_on = (next_st.state != RTKS_DEV_STANDBY); // [RULE_01] [RULE_02]
		next_st.clk_drv_on = next_st.osc_on;
		next_st.pll_locked = (next_st.state == RTKS_DEV_CLOCKING) || (next_st.state == RTKS_DEV_TRANSMIT);
		// amplifier tracks key only while enabled; key without enable is not honoured
		next_st.amp_on = (next_st.state == RTKS_DEV_TRANSMIT); // [RULE_03] [RULE_09]
		next_st.pll_mult = 6'(`RTKS_PLL_MULT); // [RULE_04]
		next_st.freq_low = next_st.amp_on && st.sw_low; // [RULE_11]
		next_st.mode = 4'h1 << next_st.state;
		// divide-by-four clock out, gated by the driver
		if (st.osc_on) begin
			next_st.div = st.div + 2'h1;
			next_st.dclk = (st.div >= 2'(`RTKS_CLK_DIV / 2)); // [RULE_05]
		end else begin
			next_st.div = '0;
			next_st.dclk = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
			st.state <= RTKS_DEV_STANDBY;
		end else begin
			st <= next_st;
		end
	end
	assign link.dev_clk = st.dclk;
	assign osc_on = st.osc_on;
	assign pll_locked = st.pll_locked;
	assign clk_drv_on = st.clk_drv_on;
	assign amp_on = st.amp_on;
	assign freq_low = st.freq_low;
	assign pll_mult = st.pll_mult;
	assign mode = st.mode;
endmodule : rtks_device
`default_nettype wire

/* File: verilog/rtks_host.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rtks_consts.svh"
module rtks_host import rtks_pkg::*; #(
	parameter int LOCK_CYC = `RTKS_LOCK_CYC
) (
	input wire logic clk,
	input wire logic srst,
	rtks_link_if.host link,
	input wire logic fsk_mode,
	input wire logic sym_valid,
	output logic sym_ready,
	input wire logic sym_data,
	input wire logic frame_end,
	output logic busy,
	output logic on_dev_clk
);
	// ===================================================
	// symbol buffer
	logic q_valid, q_ready, q_data;
	rtks_fifo #(.WIDTH(`RTKS_FIFO_WIDTH), .DEPTH(`RTKS_FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.srst(srst),
		.in_valid(sym_valid),
		.in_ready(sym_ready),
		.in_data(sym_data),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data(q_data)
	);
	typedef struct packed {
		rtks_host_state_t state;
		logic fsk;
		logic ending;
		logic [31:0] cnt;
		logic [15:0] bit_cnt;
		logic en;
		logic key;
		logic sw_oe;
		logic on_dev;
	} rtks_host_st_t;
	rtks_host_st_t st, next_st;
	logic [15:0] bit_len;
	// ===================================================
	// transmit sequencer
	always_comb begin
		next_st = st;
		q_ready = 1'b0;
		bit_len = st.fsk ? 16'(`RTKS_FSK_BIT_CYC) : 16'(`RTKS_ASK_BIT_CYC); // [RULE_13]
		if (frame_end) begin
			next_st.ending = 1'b1;
		end
		case (st.state)
			RTKS_HOST_IDLE: begin
				// a frame end arriving with the first symbol must not be lost
				next_st.ending = frame_end;
				if (q_valid) begin
					next_st.fsk = fsk_mode;
					next_st.en = 1'b1;
					next_st.cnt = '0;
					next_st.state = RTKS_HOST_WAKE;
				end
			end
			RTKS_HOST_WAKE: begin
				// own counter, key held low during lock wait
				next_st.cnt = st.cnt + 32'h0000_0001; // [RULE_07] [RULE_14]
				if (st.cnt >= 32'(LOCK_CYC - 1)) begin
					next_st.on_dev = 1'b1;
					next_st.key = st.fsk; // [RULE_10]
					next_st.bit_cnt = '0;
					next_st.state = RTKS_HOST_SEND;
				end
			end
			RTKS_HOST_SEND: begin
				if (st.bit_cnt != 16'h0000) begin
					next_st.bit_cnt = st.bit_cnt - 16'h0001;
				end else if (q_valid) begin
					q_ready = 1'b1;
					next_st.bit_cnt = bit_len - 16'h0001;
					if (st.fsk) begin
						next_st.sw_oe = !q_data; // [RULE_10] [RULE_11]
					end else begin
						next_st.key = q_data; // [RULE_09]
					end
				end else if (st.ending || frame_end) begin
					next_st.key = 1'b0; // [RULE_12]
					next_st.sw_oe = 1'b0;
					next_st.on_dev = 1'b0;
					next_st.state = RTKS_HOST_TAIL;
				end
			end
			RTKS_HOST_TAIL: begin
				// enable drops two cycles after key, never together
				next_st.state = RTKS_HOST_SLEEP;
			end
			RTKS_HOST_SLEEP: begin
				next_st.en = 1'b0; // [RULE_12] [RULE_01]
				next_st.ending = 1'b0;
				next_st.state = RTKS_HOST_IDLE;
			end
			default: next_st.state = RTKS_HOST_IDLE;
		endcase
		if (!next_st.en) begin
			next_st.key = 1'b0; // [RULE_14]
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
			st.state <= RTKS_HOST_IDLE;
		end else begin
			st <= next_st;
		end
	end
	assign link.chip_en = st.en;
	assign link.amp_key_en = st.key;
	assign link.fsk_sw_out = 1'b0;
	assign link.fsk_sw_oe = st.sw_oe;
	assign busy = (st.state != RTKS_HOST_IDLE);
	assign on_dev_clk = st.on_dev;
endmodule : rtks_host
`default_nettype wire

/* File: testbench/rtks_props.sv */
`timescale 1ns/1ns
`default_nettype none
module rtks_props #(
	parameter int LOCK_CYC = 20
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic chip_en,
	input wire logic amp_key_en,
	input wire logic fsk_sw_out,
	input wire logic fsk_sw_oe,
	input wire logic dev_clk
);
	localparam int ASK_BIT = 1000;
	localparam int FSK_BIT = 1563;
	logic [17:0] en_cnt;
	logic [10:0] key_gap;
	logic [10:0] sw_gap;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// =====
	// gap counters
	// gaps saturate while disabled, so the first edge of a frame passes
	always_ff @(posedge clk) begin
		en_cnt <= (srst || !chip_en) ? 18'h0_0000 : en_cnt + {17'h0_0000, en_cnt != 18'h3_ffff};
		if (srst || !chip_en) begin
			key_gap <= 11'h7ff;
			sw_gap <= 11'h7ff;
		end else begin
			key_gap <= $changed(amp_key_en) ? 11'h001 : key_gap + {10'h000, key_gap != 11'h7ff};
			sw_gap <= $changed(fsk_sw_oe) ? 11'h001 : sw_gap + {10'h000, sw_gap != 11'h7ff};
		end
	end
	// =====
	// link checks
	lock_wait_a: assert property ($rose(amp_key_en) |-> en_cnt >= LOCK_CYC)
		else $error("key raised before lock wait");
	key_enabled_a: assert property (amp_key_en |-> chip_en)
		else $error("key high while chip disabled");
	shut_order_a: assert property ($fell(chip_en) |-> !$past(amp_key_en, 2))
		else $error("chip disabled before key low");
	drain_low_a: assert property (fsk_sw_out == 1'b0)
		else $error("switch pin drives high");
	sw_keyed_a: assert property (fsk_sw_oe |-> amp_key_en)
		else $error("switch closed with key low");
	standby_clk_a: assert property (!chip_en [*8] |-> !dev_clk)
		else $error("clock runs in standby");
	clk_div_a: assert property ($rose(dev_clk) && chip_en && $past(chip_en, 14)
		|-> !$past(dev_clk, 1) && !$past(dev_clk, 2) && $past(dev_clk, 3) && $past(dev_clk, 4))
		else $error("clock not a quarter rate");
	ask_rate_a: assert property ($changed(amp_key_en) && chip_en |-> key_gap >= ASK_BIT)
		else $error("key changes too fast");
	fsk_rate_a: assert property ($changed(fsk_sw_oe) && chip_en |-> sw_gap >= FSK_BIT)
		else $error("switch changes too fast");
endmodule : rtks_props
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam int LC = 20;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic fsk_mode = 1'b0;
	logic sym_valid = 1'b0;
	logic sym_data = 1'b0;
	logic frame_end = 1'b0;
	logic sym_ready, busy, on_dev_clk, osc_on, pll_locked, clk_drv_on, amp_on, freq_low;
	logic [5:0] pll_mult;
	logic [3:0] mode;
	int mismatches = 0;
	int comparisons = 0;
	rtks_link_if link ();
	rtks_host #(.LOCK_CYC(LC)) u_rtks_host (.clk(clk), .srst(srst), .link(link), .fsk_mode(fsk_mode),
		.sym_valid(sym_valid), .sym_ready(sym_ready), .sym_data(sym_data), .frame_end(frame_end),
		.busy(busy), .on_dev_clk(on_dev_clk));
	rtks_device #(.LOCK_CYC(LC)) u_rtks_device (.clk(clk), .srst(srst), .link(link), .osc_on(osc_on),
		.pll_locked(pll_locked), .clk_drv_on(clk_drv_on), .amp_on(amp_on), .freq_low(freq_low),
		.pll_mult(pll_mult), .mode(mode));
	rtks_props #(.LOCK_CYC(LC)) u_rtks_props (.clk(clk), .srst(srst), .chip_en(link.chip_en),
		.amp_key_en(link.amp_key_en), .fsk_sw_out(link.fsk_sw_out), .fsk_sw_oe(link.fsk_sw_oe),
		.dev_clk(link.dev_clk));
	// =====
	// tasks
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic sel(input int k);
		logic [6:0] v;
		v = {link.fsk_sw_oe, !busy, !freq_low, !amp_on, amp_on, pll_locked, osc_on};
		return v[k];
	endfunction : sel
	// bounded wait; a wait that runs out shows up as a mismatch
	task automatic wt(input int k, input int n);
		int i;
		for (i = 0; i < n && sel(k) !== 1'b1; i++) @(negedge clk);
		chk({7'h00, sel(k)}, 8'h01);
	endtask : wt
	task automatic push(input logic b);
		int i;
		@(posedge clk);
		sym_valid <= 1'b1;
		sym_data <= b;
		@(negedge clk);
		for (i = 0; i < 9000 && sym_ready !== 1'b1; i++) @(negedge clk);
		@(posedge clk);
		sym_valid <= 1'b0;
	endtask : push
	task automatic standby();
		@(posedge clk);
		frame_end <= 1'b0;
		repeat (10) @(negedge clk);
		chk({1'b0, on_dev_clk, osc_on, pll_locked, clk_drv_on, amp_on, link.chip_en, link.dev_clk}, 8'h00);
		chk({4'h0, mode}, 8'h01);
	endtask : standby
	// =====
	// sequence
	initial begin
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		finish_test();
	end
	initial begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		standby();
		push(1'b1);
		wt(0, 10);
		chk({5'h00, clk_drv_on, amp_on, link.amp_key_en}, 8'h04);
		chk({4'h0, mode}, 8'h02);
		chk({2'h0, pll_mult}, 8'h20);
		push(1'b0);
		push(1'b1);
		push(1'b0);
		@(negedge clk);
		chk({7'h00, sym_ready}, 8'h00); // four words fill the fifo
		wt(1, LC + 10);
		// locked while the host still waits on its own clock
		chk({1'b0, on_dev_clk, amp_on, link.amp_key_en, mode}, 8'h04);
		wt(2, 2000);
		chk({2'h0, on_dev_clk, freq_low, mode}, 8'h28);
		push(1'b1);
		frame_end <= 1'b1;
		wt(3, 1100);
		wt(5, 6000);
		standby();
		@(posedge clk);
		fsk_mode <= 1'b1;
		push(1'b0);
		push(1'b1);
		frame_end <= 1'b1;
		wt(6, LC + 100);
		repeat (6) @(negedge clk);
		chk({6'h00, freq_low, amp_on}, 8'h03);
		wt(4, 2000);
		chk({7'h00, link.amp_key_en}, 8'h01);
		wt(5, 4000);
		standby();
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
